// [src/gcmd_regs.vh]
`ifndef GCMD_REGS_VH
`define GCMD_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_GCMD 8'h18
`define OFF_GSTS 8'h1c
`define OFF_IRTA 8'h20
`define OFF_CAP 8'h24
`define OFF_FLT_CNT 8'h28
// ----------------------------------------
// Command field positions
// ----------------------------------------
`define BIT_LOG_EN 28
`define BIT_FLUSH 27
`define BIT_QI_EN 26
`define BIT_IR_EN 25
`define BIT_PTR_LD 24
// ----------------------------------------
// Capability bits
// ----------------------------------------
`define CAP_LOG 0
`define CAP_FLUSH 1
`define CAP_QI 2
`define CAP_IR 3
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define RST_CAP 4'hf
`define RST_IRTA 32'h0000_0000
`define FLUSH_CYCLES 8'h08
`define LOAD_CYCLES 8'h02
`endif

// [src/op_timer.v]
`timescale 1ns/100ps
// ----------------------------------------
// One-shot operation timer: busy until count done and drained
// ----------------------------------------
module op_timer (
    mclk,
    rst_n,
    start,
    cycles,
    hold,
    busy,
    done
);
    input wire mclk;
    input wire rst_n;
    input wire start;
    input wire [7:0] cycles;
    input wire hold;
    output wire busy;
    output reg done;

    reg [7:0] cnt_q;
    reg busy_q;

    assign busy = busy_q;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= cycles;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q > 8'h01) begin
                    cnt_q <= cnt_q - 8'h01;
                end else if (!hold) begin
                    // Holds at the last count until queued work has drained
                    busy_q <= 1'b0;
                    done <= 1'b1;
                    cnt_q <= 8'h00;
                end
            end
        end
    end
endmodule

// [src/remap_global_command_upper.v]
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
// Functional notes
// - Writing 0 to bit 28 disables memory log; faults go to recording regs.
// - Writing 1 to bit 28 records faults into the memory-resident log.
// - Logging enable outcome is reflected in the logging status field.
// - Setting bit 27 flushes internal write posting buffers.
// - Flush progress is reported in the flush status field.
// - Command fields read undefined; writing 0 to one-shot fields does nothing.
// - Bit 26 enables (1) or disables (0) queued invalidation.
// - Queued invalidation enable result is reported in its status field.
// - Bit 25 enables (1) or disables (0) interrupt remapping if supported.
// - Interrupt remap enable completion is reported in its status field.
// - Remapping switches only at an interrupt transaction boundary.
// - Queued interrupts drain before remap enable completes.
// - Setting bit 24 loads the working table pointer from the address reg.
// - Table pointer load completion is reported in its status field.
// - Logging, flush and queued fields act only if the capability exists.
`include "gcmd_regs.vh"

module remap_global_command_upper (
    mclk,
    arst_n,
    addr,
    wdata,
    wr_stb,
    rd_stb,
    rdata,
    irq_busy,
    irq_boundary,
    fault_to_memory_log,
    fault_to_recording_regs,
    post_buffer_flush_busy,
    queued_inval_active,
    irq_remap_active,
    irq_table_ptr
);
    input wire mclk;
    input wire arst_n;
    input wire [7:0] addr;
    input wire [31:0] wdata;
    input wire wr_stb;
    input wire rd_stb;
    output reg [31:0] rdata;
    input wire irq_busy;
    input wire irq_boundary;
    output wire fault_to_memory_log;
    output wire fault_to_recording_regs;
    output wire post_buffer_flush_busy;
    output wire queued_inval_active;
    output wire irq_remap_active;
    output reg [31:0] irq_table_ptr;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Release is synchronous so that every flop leaves reset on one edge;
    // assertion stays asynchronous and needs no running clock
    reg rst_s1_q;
    reg rst_n_q;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Exact match only: no offset aliases onto the command register
    wire wr_cmd = wr_stb & hit(addr, `OFF_GCMD);
    wire wr_irta = wr_stb & hit(addr, `OFF_IRTA);
    wire wr_cap = wr_stb & hit(addr, `OFF_CAP);

    // ----------------------------------------
    // Software-visible registers
    // ----------------------------------------
    reg [3:0] cap_q;
    reg [31:0] irta_q;
    reg log_en_q;
    reg qi_en_q;
    reg ir_req_q;
    reg ir_en_q;
    reg ir_sts_q;
    reg ptr_sts_q;
    reg flush_sts_q;
    reg [15:0] flt_cnt_q;

    // One write carries all five fields; each is acted upon on its own
    wire log_wr = wr_cmd & cap_q[`CAP_LOG];
    wire qi_wr = wr_cmd & cap_q[`CAP_QI];
    wire ir_wr = wr_cmd & cap_q[`CAP_IR];
    // Zero on a one-shot field starts nothing
    wire flush_go = wr_cmd & cap_q[`CAP_FLUSH] &
        wdata[`BIT_FLUSH];
    wire ptr_go = wr_cmd & cap_q[`CAP_IR] & wdata[`BIT_PTR_LD];

    wire flush_done;
    wire ptr_done;
    wire ptr_busy;

    // ----------------------------------------
    // Write buffer flush sequencer
    // ----------------------------------------
    // A new request while busy reloads the count: the last one sets the end
    op_timer flush_tmr (
        .mclk(mclk),
        .rst_n(rst_n_q),
        .start(flush_go),
        .cycles(`FLUSH_CYCLES),
        .hold(1'b0),
        .busy(post_buffer_flush_busy),
        .done(flush_done)
    );

    // ----------------------------------------
    // Table pointer load sequencer
    // ----------------------------------------
    // Fixed load time; only a new load request while busy can stretch it, by reloading the count
    op_timer ptr_tmr (
        .mclk(mclk),
        .rst_n(rst_n_q),
        .start(ptr_go),
        .cycles(`LOAD_CYCLES),
        .hold(1'b0),
        .busy(ptr_busy),
        .done(ptr_done)
    );

    // ----------------------------------------
    // Capability and table address registers
    // ----------------------------------------
    // Capability bits are writable so that each optional command can be
    // switched off without a different build
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cap_q <= `RST_CAP;
        end else if (wr_cap) begin
            cap_q <= wdata[3:0];
        end
    end

    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irta_q <= `RST_IRTA;
        end else if (wr_irta) begin
            irta_q <= wdata;
        end
    end

    // ----------------------------------------
    // Fault logging route
    // ----------------------------------------
    // The field is a level, not a pulse: every write with the logging capability set takes its new value
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            log_en_q <= 1'b0;
        end else if (log_wr) begin
            log_en_q <= wdata[`BIT_LOG_EN];
        end
    end

    // Counts real changes of the route only; rewriting the same level
    // leaves it alone, so a toggle nobody asked for shows up here
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flt_cnt_q <= 16'h0000;
        end else if (log_wr && (wdata[`BIT_LOG_EN] != log_en_q)) begin
            flt_cnt_q <= flt_cnt_q + 16'h0001;
        end
    end

    assign fault_to_memory_log = log_en_q;
    assign fault_to_recording_regs = ~log_en_q;

    // ----------------------------------------
    // Queued invalidation
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            qi_en_q <= 1'b0;
        end else if (qi_wr) begin
            qi_en_q <= wdata[`BIT_QI_EN];
        end
    end

    assign queued_inval_active = qi_en_q;

    // ----------------------------------------
    // Write buffer flush status
    // ----------------------------------------
    // A request in the cycle of a completion wins: the timer has just
    // been restarted, so the flush is still running
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flush_sts_q <= 1'b0;
        end else if (flush_go) begin
            flush_sts_q <= 1'b1;
        end else if (flush_done) begin
            flush_sts_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Table pointer load
    // ----------------------------------------
    // Status drops on the request and rises with the pointer itself, so
    // it is never seen set beside a stale pointer
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ptr_sts_q <= 1'b0;
        end else if (ptr_go) begin
            ptr_sts_q <= 1'b0;
        end else if (ptr_done) begin
            ptr_sts_q <= 1'b1;
        end
    end

    // Limitation: the address is taken at completion, so rewriting it
    // while a load runs changes what gets loaded
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_table_ptr <= `RST_IRTA;
        end else if (ptr_done) begin
            irq_table_ptr <= irta_q;
        end
    end

    // ----------------------------------------
    // Interrupt remapping switch
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ir_req_q <= 1'b0;
        end else if (ir_wr) begin
            ir_req_q <= wdata[`BIT_IR_EN];
        end
    end

    // Switch only between interrupts and once the queue has drained; a
    // source that never goes quiet holds the request off indefinitely
    wire ir_switch = (ir_req_q != ir_en_q) && irq_boundary && !irq_busy;

    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ir_en_q <= 1'b0;
        end else if (ir_switch) begin
            ir_en_q <= ir_req_q;
        end
    end

    // Status moves on the same edge as the switch itself
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ir_sts_q <= 1'b0;
        end else if (ir_switch) begin
            ir_sts_q <= ir_req_q;
        end
    end

    assign irq_remap_active = ir_en_q;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Only the five upper status fields live here; the rest read zero
    wire [31:0] sts_word = {3'b000, log_en_q, flush_sts_q, qi_en_q,
        ir_sts_q, ptr_sts_q, 24'h000000};

    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (addr)
                `OFF_GCMD: rdata <= 32'h0000_0000;
                `OFF_GSTS: rdata <= sts_word;
                `OFF_IRTA: rdata <= irta_q;
                `OFF_CAP: rdata <= {28'h0000000, cap_q};
                `OFF_FLT_CNT: rdata <= {16'h0000, flt_cnt_q};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            // Zero between answers, so a stale word is never taken for one
            rdata <= 32'h0000_0000;
        end
    end
endmodule

// [test/remap_global_command_upper_props.sv]
`timescale 1ns/100ps
`include "gcmd_regs.vh"
module remap_global_command_upper_props (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic irq_busy,
    input wire logic irq_boundary,
    input wire logic fault_to_memory_log,
    input wire logic fault_to_recording_regs,
    input wire logic post_buffer_flush_busy,
    input wire logic queued_inval_active,
    input wire logic irq_remap_active,
    input wire logic [31:0] irq_table_ptr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Shadow of capability and table address
    // ----------------------------------------
    logic [3:0] cap_q;
    logic [31:0] irta_q;
    wire cmd = wr_stb && addr == `OFF_GCMD;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cap_q <= `RST_CAP;
            irta_q <= `RST_IRTA;
        end else if (wr_stb && addr == `OFF_CAP) begin
            cap_q <= wdata[3:0];
        end else if (wr_stb && addr == `OFF_IRTA) begin
            irta_q <= wdata;
        end
    end
    property p_inv;
        fault_to_recording_regs == !fault_to_memory_log;
    endproperty
    a_inv: assert property (p_inv) else $error("log route");
    property p_log;
        cmd && cap_q[0] |=> fault_to_memory_log == $past(wdata[28]);
    endproperty
    a_log: assert property (p_log) else $error("log enable");
    property p_qi;
        cmd && cap_q[2] |=> queued_inval_active == $past(wdata[26]);
    endproperty
    a_qi: assert property (p_qi) else $error("qi enable");
    property p_fl;
        cmd && cap_q[1] && wdata[27] |=> post_buffer_flush_busy;
    endproperty
    a_fl: assert property (p_fl) else $error("flush start");
    property p_fl_end;
        $rose(post_buffer_flush_busy) |-> ##[6:9] !post_buffer_flush_busy;
    endproperty
    a_fl_end: assert property (p_fl_end) else $error("flush end");
    property p_nofl;
        cmd && !wdata[27] && !post_buffer_flush_busy |=>
            !post_buffer_flush_busy;
    endproperty
    a_nofl: assert property (p_nofl) else $error("flush on 0");
    // Remap may only flip at a quiet boundary with nothing queued
    property p_ir;
        $changed(irq_remap_active) |-> $past(irq_boundary && !irq_busy);
    endproperty
    a_ir: assert property (p_ir) else $error("remap switch");
    property p_ptr;
        cmd && cap_q[3] && wdata[24] |-> ##[1:4] irq_table_ptr == irta_q;
    endproperty
    a_ptr: assert property (p_ptr) else $error("ptr load");
    c_fl: cover property (cmd && wdata[27]);
    c_ir: cover property ($rose(irq_remap_active));
    c_ptr: cover property (cmd && wdata[24]);
endmodule
bind remap_global_command_upper remap_global_command_upper_props u_props (
    .mclk(mclk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .irq_busy(irq_busy),
    .irq_boundary(irq_boundary),
    .fault_to_memory_log(fault_to_memory_log),
    .fault_to_recording_regs(fault_to_recording_regs),
    .post_buffer_flush_busy(post_buffer_flush_busy),
    .queued_inval_active(queued_inval_active),
    .irq_remap_active(irq_remap_active),
    .irq_table_ptr(irq_table_ptr)
);

// [test/remap_global_command_upper_tb.sv]
`timescale 1ns/100ps
`include "gcmd_regs.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
$display("Error %s exp %h got %h", n, e, a); end end
module remap_global_command_upper_tb;
    logic mclk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0;
    logic irq_busy = 0, irq_boundary = 1;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, irq_table_ptr;
    logic fault_to_memory_log, fault_to_recording_regs;
    logic post_buffer_flush_busy, queued_inval_active, irq_remap_active;
    int fails = 0, check_count = 0;
    remap_global_command_upper u_dut (
        .mclk(mclk),
        .arst_n(arst_n),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .irq_busy(irq_busy),
        .irq_boundary(irq_boundary),
        .fault_to_memory_log(fault_to_memory_log),
        .fault_to_recording_regs(fault_to_recording_regs),
        .post_buffer_flush_busy(post_buffer_flush_busy),
        .queued_inval_active(queued_inval_active),
        .irq_remap_active(irq_remap_active),
        .irq_table_ptr(irq_table_ptr)
    );
    initial forever #50 mclk = ~mclk;
    // ----------------------------------------
    // Register port tasks
    // ----------------------------------------
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1;
        @(posedge mclk);
        wr_stb <= 0;
        #1;
    endtask
    task automatic rd(input [7:0] a, input [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1;
        @(posedge mclk);
        rd_stb <= 0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task print_verdict;
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Tests need well under 200 cycles
    initial begin
        #50000;
        fails++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1;
        cyc(1);
        `CHK("rec", 1'b1, fault_to_recording_regs)
        cyc(2);
        rd(`OFF_CAP, 32'h0000_000f);
        rd(`OFF_GSTS, 32'h0000_0000);
        // Fault-log pointer counts as set outside the block by now
        wr(`OFF_IRTA, 32'hcafe_f000);
        wr(`OFF_GCMD, 32'h1d00_0000);
        `CHK("flush", 1'b1, post_buffer_flush_busy)
        `CHK("log", 1'b1, fault_to_memory_log)
        `CHK("rec", 1'b0, fault_to_recording_regs)
        `CHK("qi", 1'b1, queued_inval_active)
        rd(`OFF_GSTS, 32'h1c00_0000);
        cyc(12);
        `CHK("flush", 1'b0, post_buffer_flush_busy)
        `CHK("ptr", 32'hcafe_f000, irq_table_ptr)
        rd(`OFF_GSTS, 32'h1500_0000);
        @(posedge mclk) irq_busy <= 1'b1;
        wr(`OFF_GCMD, 32'h1600_0000);
        cyc(4);
        `CHK("ire", 1'b0, irq_remap_active)
        rd(`OFF_GSTS, 32'h1500_0000);
        @(posedge mclk) irq_busy <= 1'b0;
        cyc(3);
        `CHK("ire", 1'b1, irq_remap_active)
        rd(`OFF_GSTS, 32'h1700_0000);
        @(posedge mclk) irq_boundary <= 1'b0;
        wr(`OFF_GCMD, 32'h1400_0000);
        cyc(3);
        `CHK("ire", 1'b1, irq_remap_active)
        @(posedge mclk) irq_boundary <= 1'b1;
        cyc(3);
        `CHK("ire", 1'b0, irq_remap_active)
        rd(`OFF_GCMD, 32'h0000_0000);
        // A new table under live remapping would have to map alike
        wr(`OFF_IRTA, 32'h1234_5000);
        rd(`OFF_IRTA, 32'h1234_5000);
        wr(`OFF_GCMD, 32'h1400_0000);
        cyc(4);
        `CHK("flush", 1'b0, post_buffer_flush_busy)
        `CHK("ptr", 32'hcafe_f000, irq_table_ptr)
        wr(`OFF_CAP, 32'h0000_0000);
        wr(`OFF_GCMD, 32'h0900_0000);
        cyc(4);
        `CHK("flush", 1'b0, post_buffer_flush_busy)
        `CHK("log", 1'b1, fault_to_memory_log)
        `CHK("qi", 1'b1, queued_inval_active)
        `CHK("ptr", 32'hcafe_f000, irq_table_ptr)
        wr(`OFF_CAP, 32'h0000_000f);
        wr(`OFF_GCMD, 32'h0000_0000);
        `CHK("rec", 1'b1, fault_to_recording_regs)
        `CHK("qi", 1'b0, queued_inval_active)
        rd(`OFF_FLT_CNT, 32'h0000_0002);
        rd(8'h40, 32'h0000_0000);
        // Reset in mid-run clears at once and needs the same release
        @(posedge mclk) arst_n <= 1'b0;
        #1 `CHK("ptr", 32'h0000_0000, irq_table_ptr)
        cyc(2);
        @(posedge mclk) arst_n <= 1'b1;
        cyc(2);
        wr(`OFF_GCMD, 32'h1000_0000);
        `CHK("log", 1'b1, fault_to_memory_log)
        rd(`OFF_CAP, 32'h0000_000f);
        print_verdict;
    end
endmodule
